// [src/ipw_irq_wake.sv]
// interrupt priority arbiter, pin triggering and idle/halt wake-up control with APB registers
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module ipw_irq_wake (
  input wire logic pclk,
  input wire logic presetn,
  input wire ipw_pkg::ipw_apb_req_t apb_req,
  output ipw_pkg::ipw_apb_rsp_t apb_rsp,
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire logic ext_irq_pin2,
  input wire logic [31:0] port_pins,
  input wire logic [9:0] periph_evt,
  input wire ipw_pkg::ipw_cpu_in_t cpu_in,
  output ipw_pkg::ipw_cpu_out_t cpu_out
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [1:0] src_level(input ipw_pkg::ipw_state_t s, input int idx);
    logic [1:0] lvl;
    lvl = 2'b00;
    // sources 0..5 sit on basic bits 0..5
    if (idx < 6)
    begin
      lvl = {s.priority_high_basic[idx], s.priority_low_basic[idx]};
    end
    // sources 6..13 sit on extended bits 0..7
    else
    begin
      lvl = {s.priority_high_extended[idx - 6], s.priority_low_extended[idx - 6]};
    end
    return lvl;
  endfunction

  function automatic logic reg_hit(input logic [11:0] addr, input logic [9:0] idx);
    return (addr[1:0] == 2'b00) && (addr[11:2] == idx);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] addr);
    return reg_hit(addr, ipw_pkg::IDX_POWER_CONTROL) || reg_hit(addr, ipw_pkg::IDX_PRIO_LOW_BASIC) ||
      reg_hit(addr, ipw_pkg::IDX_PRIO_HIGH_BASIC) || reg_hit(addr, ipw_pkg::IDX_PRIO_LOW_EXT) ||
      reg_hit(addr, ipw_pkg::IDX_PRIO_HIGH_EXT) || reg_hit(addr, ipw_pkg::IDX_IRQ_ENABLE) ||
      reg_hit(addr, ipw_pkg::IDX_TRIGGER) || reg_hit(addr, ipw_pkg::IDX_PORT_WAKE) ||
      reg_hit(addr, ipw_pkg::IDX_FLAGS) || reg_hit(addr, ipw_pkg::IDX_STATUS);
  endfunction

  ipw_pkg::ipw_state_t st_r;
  ipw_pkg::ipw_state_t st_nxt;

  assign apb_rsp = st_r.apb;
  assign cpu_out = st_r.cpu;

  // ****************************************
  // next-state logic
  // ****************************************
  always_comb
  begin
    logic [2:0] pin_en;
    logic [2:0] pin_low;
    logic [2:0] pin_qual;
    logic [7:0] thr;
    logic [7:0] cnt;
    logic [13:0] hw_set;
    logic [13:0] sw_clr;
    logic [13:0] pend;
    logic [31:0] port_chg;
    logic [1:0] top_lvl;
    logic any_active;
    logic cand;
    logic [3:0] cand_vec;
    logic [1:0] cand_lvl;
    logic any_pend;
    logic halt_block;
    logic halt_wake;
    logic acc;
    logic wr;
    logic [31:0] rd;
    st_nxt = st_r;
    pin_en = {st_r.src_enable[ipw_pkg::SRC_PIN2], st_r.src_enable[ipw_pkg::SRC_PIN1],
      st_r.src_enable[ipw_pkg::SRC_PIN0]};
    pin_low = ~st_r.pin_s2;
    pin_qual = 3'b000;
    hw_set = ipw_pkg::RST_SRC;
    sw_clr = ipw_pkg::RST_SRC;
    cnt = 8'h00;
    thr = ipw_pkg::IDLE_TRIG_CLKS;

    // pin synchronisers
    st_nxt.pin_s1 = {ext_irq_pin2, ext_irq_pin1, ext_irq_pin0};
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.port_s1 = port_pins;
    st_nxt.port_s2 = st_r.port_s1;
    st_nxt.port_prev = st_r.port_s2;

    // idle/run needs more than one clock low
    // halt needs more than 128 clocks low
    // a low that began in halt keeps the long threshold after the wake it caused
    for (int i = 0; i < 3; i++)
    begin
      thr = (st_r.pin_from_halt[i] || st_r.mode == ipw_pkg::MODE_HALT) ? ipw_pkg::HALT_TRIG_CLKS :
        ipw_pkg::IDLE_TRIG_CLKS;
      st_nxt.pin_from_halt[i] = pin_low[i] && (st_r.pin_from_halt[i] || st_r.mode == ipw_pkg::MODE_HALT);
      cnt = st_r.pin_low_cnt[i * 8 +: 8];
      if (pin_low[i])
      begin
        if (cnt != ipw_pkg::CNT_MAX)
        begin
          cnt = cnt + 8'h01;
        end
      end
      else
      begin
        cnt = 8'h00;
      end
      st_nxt.pin_low_cnt[i * 8 +: 8] = cnt;
      pin_qual[i] = st_r.pin_low_cnt[i * 8 +: 8] > thr;
    end
    st_nxt.pin_qual_prev = pin_qual;

    // pins zero/one: falling edge or low level
    // type 0 level, type 1 edge
    hw_set[ipw_pkg::SRC_PIN0] = st_r.trigger_type[0] ? (pin_qual[0] & ~st_r.pin_qual_prev[0]) : pin_qual[0];
    hw_set[ipw_pkg::SRC_PIN1] = st_r.trigger_type[1] ? (pin_qual[1] & ~st_r.pin_qual_prev[1]) : pin_qual[1];
    hw_set[ipw_pkg::SRC_PIN2] = pin_qual[2] & ~st_r.pin_qual_prev[2];
    // change of any wake-enabled port pin
    port_chg = (st_r.port_s2 ^ st_r.port_prev) & st_r.port_wake_enable;
    hw_set[ipw_pkg::SRC_PORT_CHANGE] = |port_chg;
    hw_set[ipw_pkg::SRC_TIMER0] = periph_evt[0];
    hw_set[ipw_pkg::SRC_TIMER1] = periph_evt[1];
    hw_set[ipw_pkg::SRC_UART] = periph_evt[2];
    hw_set[ipw_pkg::SRC_TIMER2] = periph_evt[3];
    hw_set[ipw_pkg::SRC_TIMER3] = periph_evt[4];
    hw_set[ipw_pkg::SRC_CONV_TOUCH] = periph_evt[5];
    hw_set[ipw_pkg::SRC_SERIAL_BUS] = periph_evt[6];
    hw_set[ipw_pkg::SRC_LOWVOLT] = periph_evt[7];
    hw_set[ipw_pkg::SRC_COMPARATOR] = periph_evt[8];
    hw_set[ipw_pkg::SRC_PULSE_WIDTH] = periph_evt[9];

    // ****************************************
    // arbitration
    // ****************************************
    // individual and global enable both needed
    pend = st_r.global_irq_enable ? (st_r.flags & st_r.src_enable) : ipw_pkg::RST_SRC;
    any_pend = |pend;
    cand = 1'b0;
    cand_vec = 4'h0;
    cand_lvl = 2'b00;
    // two bits, 11 highest, 00 lowest
    // strict greater keeps the lowest vector on ties
    for (int i = 0; i < ipw_pkg::NSRC; i++)
    begin
      if (pend[i] && (!cand || (src_level(st_r, i) > cand_lvl)))
      begin
        cand = 1'b1;
        cand_vec = 4'(i);
        cand_lvl = src_level(st_r, i);
      end
    end
    any_active = |st_r.in_service;
    top_lvl = st_r.in_service[3] ? 2'b11 : st_r.in_service[2] ? 2'b10 : st_r.in_service[1] ? 2'b01 : 2'b00;
    // only a strictly higher level preempts
    if (any_active && (cand_lvl <= top_lvl))
    begin
      cand = 1'b0;
    end

    // acknowledge and return
    if (cpu_in.irq_ack && st_r.cpu.irq_req)
    begin
      sw_clr[st_r.cpu.irq_vec] = 1'b1;
      st_nxt.in_service[st_r.cpu.irq_level] = 1'b1;
    end
    else if (cpu_in.reti && any_active)
    begin
      st_nxt.in_service[top_lvl] = 1'b0;
    end

    // ****************************************
    // APB slave
    // ****************************************
    acc = apb_req.psel && apb_req.penable;
    wr = acc && st_r.apb.pready && apb_req.pwrite;
    st_nxt.apb.pready = acc && !st_r.apb.pready;
    st_nxt.apb.pslverr = acc && !st_r.apb.pready && !addr_mapped(apb_req.paddr);
    rd = ipw_pkg::RST_WORD;
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_POWER_CONTROL))
    begin
      rd[7:0] = st_r.power_control;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_LOW_BASIC))
    begin
      rd[7:0] = st_r.priority_low_basic;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_HIGH_BASIC))
    begin
      rd[7:0] = st_r.priority_high_basic;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_LOW_EXT))
    begin
      rd[7:0] = st_r.priority_low_extended;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_HIGH_EXT))
    begin
      rd[7:0] = st_r.priority_high_extended;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_IRQ_ENABLE))
    begin
      rd[ipw_pkg::ENABLE_GLOBAL_BIT] = st_r.global_irq_enable;
      rd[13:0] = st_r.src_enable;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_TRIGGER))
    begin
      rd[1:0] = st_r.trigger_type;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PORT_WAKE))
    begin
      rd = st_r.port_wake_enable;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_FLAGS))
    begin
      rd[13:0] = st_r.flags;
    end
    if (reg_hit(apb_req.paddr, ipw_pkg::IDX_STATUS))
    begin
      rd[11:0] = {st_r.in_service, st_r.pin_s2, ~pin_en & 3'b000, st_r.mode};
    end
    if (acc && !st_r.apb.pready)
    begin
      st_nxt.apb.prdata = apb_req.pwrite ? ipw_pkg::RST_WORD : rd;
    end

    halt_block = |(pin_low & pin_en);
    if (wr)
    begin
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_POWER_CONTROL))
      begin
        st_nxt.power_control = apb_req.pwdata[7:0] & ipw_pkg::POWER_CONTROL_RW_MASK;
        // power-down refused while an enabled pin is low
        if (halt_block)
        begin
          st_nxt.power_control[ipw_pkg::POWER_CONTROL_PD_BIT] = 1'b0;
        end
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_LOW_BASIC))
      begin
        st_nxt.priority_low_basic = apb_req.pwdata[7:0] & ipw_pkg::PRIO_BASIC_MASK;
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_HIGH_BASIC))
      begin
        st_nxt.priority_high_basic = apb_req.pwdata[7:0] & ipw_pkg::PRIO_BASIC_MASK;
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_LOW_EXT))
      begin
        st_nxt.priority_low_extended = apb_req.pwdata[7:0];
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PRIO_HIGH_EXT))
      begin
        st_nxt.priority_high_extended = apb_req.pwdata[7:0];
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_IRQ_ENABLE))
      begin
        st_nxt.global_irq_enable = apb_req.pwdata[ipw_pkg::ENABLE_GLOBAL_BIT];
        st_nxt.src_enable = apb_req.pwdata[13:0];
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_TRIGGER))
      begin
        st_nxt.trigger_type = apb_req.pwdata[1:0];
      end
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_PORT_WAKE))
      begin
        st_nxt.port_wake_enable = apb_req.pwdata;
      end
      // writing 0 clears a flag, 1 leaves it
      if (reg_hit(apb_req.paddr, ipw_pkg::IDX_FLAGS))
      begin
        sw_clr = sw_clr | ~apb_req.pwdata[13:0];
      end
    end

    // hardware set wins over any clear
    st_nxt.flags = (st_r.flags & ~sw_clr) | hw_set;

    // ****************************************
    // power mode control
    // ****************************************
    // enabled pins, wake-enabled port change and enabled timer3 only
    // enabled pin wakes without global enable
    // port wake needs only its wake enable
    halt_wake = (|(pin_low & pin_en)) || (|port_chg) ||
      (st_r.src_enable[ipw_pkg::SRC_TIMER3] && st_r.flags[ipw_pkg::SRC_TIMER3]);
    st_nxt.cpu.slot_first = st_r.cpu.slot_first && !cpu_in.slot_done;
    unique case (st_r.mode)
      ipw_pkg::MODE_RUN:
      begin
        if (st_r.power_control[ipw_pkg::POWER_CONTROL_PD_BIT])
        begin
          st_nxt.mode = ipw_pkg::MODE_HALT;
        end
        else if (st_r.power_control[ipw_pkg::POWER_CONTROL_IDLE_BIT])
        begin
          st_nxt.mode = ipw_pkg::MODE_IDLE;
        end
      end
      ipw_pkg::MODE_IDLE:
      begin
        if (any_pend)
        begin
          st_nxt.mode = ipw_pkg::MODE_RUN;
          st_nxt.power_control[ipw_pkg::POWER_CONTROL_IDLE_BIT] = 1'b0;
        end
      end
      ipw_pkg::MODE_HALT:
      begin
        if (halt_wake)
        begin
          st_nxt.mode = ipw_pkg::MODE_WAKE;
          st_nxt.power_control[ipw_pkg::POWER_CONTROL_PD_BIT] = 1'b0;
        end
      end
      ipw_pkg::MODE_WAKE:
      begin
        // one-cycle (not long) next instruction runs before service
        st_nxt.mode = ipw_pkg::MODE_RUN;
        st_nxt.cpu.slot_first = !cpu_in.next_insn_long;
      end
    endcase
    st_nxt.cpu.idle_mode = (st_nxt.mode == ipw_pkg::MODE_IDLE);
    st_nxt.cpu.halt_mode = (st_nxt.mode == ipw_pkg::MODE_HALT) || (st_nxt.mode == ipw_pkg::MODE_WAKE);

    // idle exit requests service in the same cycle
    st_nxt.cpu.irq_req = cand && !st_nxt.cpu.halt_mode && !st_nxt.cpu.slot_first &&
      !(cpu_in.irq_ack && st_r.cpu.irq_req) && (st_r.mode != ipw_pkg::MODE_IDLE || any_pend);
    st_nxt.cpu.irq_vec = cand_vec;
    st_nxt.cpu.irq_level = cand_lvl;
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.mode <= ipw_pkg::MODE_RUN;
      st_r.pin_s1 <= 3'b111;
      st_r.pin_s2 <= 3'b111;
      st_r.pin_qual_prev <= 3'b000;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule

// [src/ipw_pkg.sv]
// package: register map, field layout, timing counts and carrier types of the interrupt/wake block
package ipw_pkg;

  // ****************************************
  // register indices (byte address = 4 * index)
  // ****************************************
  localparam logic [9:0] IDX_POWER_CONTROL = 10'h087;
  localparam logic [9:0] IDX_PRIO_LOW_BASIC = 10'h0B8;
  localparam logic [9:0] IDX_PRIO_HIGH_BASIC = 10'h0B9;
  localparam logic [9:0] IDX_PRIO_LOW_EXT = 10'h0BA;
  localparam logic [9:0] IDX_PRIO_HIGH_EXT = 10'h0BB;
  localparam logic [9:0] IDX_IRQ_ENABLE = 10'h0C0;
  localparam logic [9:0] IDX_TRIGGER = 10'h0C1;
  localparam logic [9:0] IDX_PORT_WAKE = 10'h0C2;
  localparam logic [9:0] IDX_FLAGS = 10'h0C3;
  localparam logic [9:0] IDX_STATUS = 10'h0C4;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int NSRC = 14;
  localparam int POWER_CONTROL_IDLE_BIT = 0;
  localparam int POWER_CONTROL_PD_BIT = 1;
  localparam logic [7:0] POWER_CONTROL_RW_MASK = 8'h8F;
  localparam logic [7:0] PRIO_BASIC_MASK = 8'h3F;
  localparam int ENABLE_GLOBAL_BIT = 15;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [13:0] RST_SRC = 14'h0000;

  // source numbers, in ascending vector order
  localparam logic [3:0] SRC_PIN0 = 4'h0;
  localparam logic [3:0] SRC_TIMER0 = 4'h1;
  localparam logic [3:0] SRC_PIN1 = 4'h2;
  localparam logic [3:0] SRC_TIMER1 = 4'h3;
  localparam logic [3:0] SRC_UART = 4'h4;
  localparam logic [3:0] SRC_TIMER2 = 4'h5;
  localparam logic [3:0] SRC_TIMER3 = 4'h6;
  localparam logic [3:0] SRC_PORT_CHANGE = 4'h7;
  localparam logic [3:0] SRC_PIN2 = 4'h8;
  localparam logic [3:0] SRC_CONV_TOUCH = 4'h9;
  localparam logic [3:0] SRC_SERIAL_BUS = 4'hA;
  localparam logic [3:0] SRC_LOWVOLT = 4'hB;
  localparam logic [3:0] SRC_COMPARATOR = 4'hC;
  localparam logic [3:0] SRC_PULSE_WIDTH = 4'hD;

  // ****************************************
  // timing counts (system clocks a pin trigger must exceed)
  // ****************************************
  localparam logic [7:0] IDLE_TRIG_CLKS = 8'h01;
  localparam logic [7:0] HALT_TRIG_CLKS = 8'h80;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_HALT = 2'b01,
    MODE_WAKE = 2'b11,
    MODE_IDLE = 2'b10
  } ipw_mode_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ipw_apb_req_t;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } ipw_apb_rsp_t;

  typedef struct packed {
    logic irq_ack;
    logic reti;
    logic next_insn_long;
    logic slot_done;
  } ipw_cpu_in_t;

  typedef struct packed {
    logic irq_req;
    logic [3:0] irq_vec;
    logic [1:0] irq_level;
    logic idle_mode;
    logic halt_mode;
    logic slot_first;
  } ipw_cpu_out_t;

  typedef struct packed {
    ipw_apb_rsp_t apb;
    ipw_cpu_out_t cpu;
    ipw_mode_t mode;
    logic [7:0] power_control;
    logic [7:0] priority_low_basic;
    logic [7:0] priority_high_basic;
    logic [7:0] priority_low_extended;
    logic [7:0] priority_high_extended;
    logic [13:0] src_enable;
    logic global_irq_enable;
    logic [1:0] trigger_type;
    logic [31:0] port_wake_enable;
    logic [13:0] flags;
    logic [3:0] in_service;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_qual_prev;
    logic [2:0] pin_from_halt;
    logic [23:0] pin_low_cnt;
    logic [31:0] port_s1;
    logic [31:0] port_s2;
    logic [31:0] port_prev;
  } ipw_state_t;

endpackage

// [testbench/ipw_irq_wake_sva.sv]
// checker: port-level properties of the interrupt and wake block
`timescale 1ns/1ps
module ipw_irq_wake_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire ipw_pkg::ipw_apb_req_t apb_req,
  input wire ipw_pkg::ipw_apb_rsp_t apb_rsp,
  input wire logic ext_irq_pin0,
  input wire logic ext_irq_pin1,
  input wire logic ext_irq_pin2,
  input wire logic [31:0] port_pins,
  input wire logic [9:0] periph_evt,
  input wire ipw_pkg::ipw_cpu_in_t cpu_in,
  input wire ipw_pkg::ipw_cpu_out_t cpu_out
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [31:0] port_prev_r;
  logic wr_pc;
  logic pins_hi;
  logic quiet;
  assign pins_hi = ext_irq_pin0 && ext_irq_pin1 && ext_irq_pin2;
  assign wr_pc = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_rsp.pready
    && apb_req.paddr == {ipw_pkg::IDX_POWER_CONTROL, 2'b00};
  // nothing that could wake a halted core: pins, port, timer3 event, bus
  assign quiet = pins_hi && !periph_evt[4] && !apb_req.psel && port_pins == port_prev_r;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      port_prev_r <= 32'h0;
    else
      port_prev_r <= port_pins;

  a_pd_halt: assert property (
    (pins_hi[*4]) ##0 (wr_pc && apb_req.pwdata[1]) |-> ##[1:2] cpu_out.halt_mode)
    else $error("power-down write did not halt");
  a_idle_entry: assert property (
    wr_pc && apb_req.pwdata[0] && !apb_req.pwdata[1] |-> ##[1:2] cpu_out.idle_mode)
    else $error("idle write did not idle");
  a_halt_holds: assert property (
    quiet[*2] ##1 (quiet && cpu_out.halt_mode)[*3] |=> cpu_out.halt_mode)
    else $error("halt left without a wake source");
  a_slot_blocks: assert property (
    cpu_out.slot_first |-> !cpu_out.irq_req)
    else $error("request during post-halt slot");
  a_halt_noreq: assert property (
    cpu_out.halt_mode |-> !cpu_out.irq_req)
    else $error("request while halted");
  a_idle_svc: assert property (
    $fell(cpu_out.idle_mode) |-> cpu_out.irq_req)
    else $error("idle left without service request");
  a_ack_drop: assert property (
    cpu_in.irq_ack && cpu_out.irq_req |=> !cpu_out.irq_req)
    else $error("request stayed after ack");
  a_vec_range: assert property (
    cpu_out.irq_req |-> cpu_out.irq_vec <= ipw_pkg::SRC_PULSE_WIDTH)
    else $error("vector out of range");
  a_apb_answer: assert property (
    apb_req.psel && !apb_req.penable |-> ##2 apb_rsp.pready)
    else $error("register access not answered");

  c_idle_wake: cover property ($fell(cpu_out.idle_mode));
  c_halt: cover property ($rose(cpu_out.halt_mode));
  c_slot: cover property (cpu_out.slot_first ##1 !cpu_out.slot_first);
endmodule

bind ipw_irq_wake ipw_irq_wake_chk i_chk (.pclk(pclk), .presetn(presetn), .apb_req(apb_req),
  .apb_rsp(apb_rsp), .ext_irq_pin0(ext_irq_pin0), .ext_irq_pin1(ext_irq_pin1), .ext_irq_pin2(ext_irq_pin2),
  .port_pins(port_pins), .periph_evt(periph_evt), .cpu_in(cpu_in), .cpu_out(cpu_out));

// [testbench/ipw_cpu_model.sv]
// partner: behavioural core that takes, services and returns from interrupts
`timescale 1ns/1ps
module ipw_cpu_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ipw_pkg::ipw_cpu_out_t cpu_out,
  input wire logic [3:0] ack_dly,
  input wire logic [7:0] svc_len,
  input wire logic long_insn,
  output ipw_pkg::ipw_cpu_in_t cpu_in,
  output logic [7:0] ack_cnt,
  output logic [3:0] ack_vec
);
  logic [3:0] wait_r;
  logic [7:0] svc_r;
  logic [3:0] depth_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cpu_in <= '0;
      ack_cnt <= 8'h0;
      ack_vec <= 4'h0;
      wait_r <= 4'h0;
      svc_r <= 8'h0;
      depth_r <= 4'h0;
    end
    else
    begin
      cpu_in.irq_ack <= 1'b0;
      cpu_in.reti <= 1'b0;
      cpu_in.next_insn_long <= long_insn;
      cpu_in.slot_done <= cpu_out.slot_first && !cpu_in.slot_done;
      if (cpu_out.irq_req && !cpu_in.irq_ack && wait_r >= ack_dly)
      begin
        cpu_in.irq_ack <= 1'b1;
        ack_cnt <= ack_cnt + 8'h1;
        ack_vec <= cpu_out.irq_vec;
        depth_r <= depth_r + 4'h1;
        svc_r <= svc_len;
        wait_r <= 4'h0;
      end
      else
      begin
        wait_r <= cpu_out.irq_req ? wait_r + 4'h1 : 4'h0;
        if (depth_r != 4'h0 && svc_r == 8'h0)
        begin
          cpu_in.reti <= 1'b1;
          depth_r <= depth_r - 4'h1;
          svc_r <= svc_len;
        end
        else if (depth_r != 4'h0)
          svc_r <= svc_r - 8'h1;
      end
    end
  end
endmodule

// [testbench/tb_ipw_irq_wake.sv]
// testbench: registers, arbitration, pin triggers and low-power wake
`timescale 1ns/1ps
module tb_ipw_irq_wake;
  localparam logic [9:0] RIX [11] = '{ipw_pkg::IDX_POWER_CONTROL, ipw_pkg::IDX_PRIO_LOW_BASIC,
    ipw_pkg::IDX_PRIO_HIGH_BASIC, ipw_pkg::IDX_PRIO_LOW_EXT, ipw_pkg::IDX_PRIO_HIGH_EXT, ipw_pkg::IDX_IRQ_ENABLE,
    ipw_pkg::IDX_TRIGGER, ipw_pkg::IDX_PORT_WAKE, ipw_pkg::IDX_FLAGS, ipw_pkg::IDX_STATUS, 10'h3FF};
  localparam logic [3:0] EVT_SRC [10] = '{4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD};
  localparam logic [31:0] HEN [5] = '{32'h8106, 32'h8100, 32'h0100, 32'h0080, 32'h8080};
  localparam logic [7:0] HNA [5] = '{8'h1, 8'h1, 8'h0, 8'h0, 8'h1};
  localparam logic [3:0] HVE [5] = '{4'h1, 4'h8, 4'h0, 4'h0, 4'h7};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  ipw_pkg::ipw_apb_req_t apb_req = '0;
  ipw_pkg::ipw_apb_rsp_t apb_rsp;
  ipw_pkg::ipw_cpu_in_t cpu_in;
  ipw_pkg::ipw_cpu_out_t cpu_out;
  logic [2:0] pin = 3'h7;
  logic [31:0] port_pins = 32'h0;
  logic [9:0] periph_evt = 10'h0;
  logic [3:0] ack_dly = 4'h0;
  logic [7:0] svc_len = 8'h28;
  logic long_insn = 1'b0;
  logic [7:0] ack_cnt;
  logic [3:0] ack_vec;
  logic [31:0] rd;
  logic err;
  logic [7:0] pr [4];
  int miscompares = 0;
  int n_tests = 0;

  always #25 pclk = ~pclk;

  ipw_irq_wake i_dut (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .ext_irq_pin0(pin[0]), .ext_irq_pin1(pin[1]), .ext_irq_pin2(pin[2]), .port_pins(port_pins),
    .periph_evt(periph_evt), .cpu_in(cpu_in), .cpu_out(cpu_out));
  ipw_cpu_model i_cpu (.pclk(pclk), .presetn(presetn), .cpu_out(cpu_out), .ack_dly(ack_dly),
    .svc_len(svc_len), .long_insn(long_insn), .cpu_in(cpu_in), .ack_cnt(ack_cnt), .ack_vec(ack_vec));

  // ****
  // helpers
  // ****
  task automatic results;
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic apb(input logic w, input int r, input logic [31:0] d);
    apb_req <= '{1'b1, 1'b0, w, {RIX[r], 2'b00}, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do
      @(posedge pclk);
    while (apb_rsp.pready !== 1'b1);
    rd = apb_rsp.prdata;
    err = apb_rsp.pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic fire(input logic [9:0] ev);
    logic [7:0] n0;
    int n;
    n0 = ack_cnt;
    periph_evt <= ev;
    @(posedge pclk);
    periph_evt <= 10'h0;
    for (n = 0; n < 60 && ack_cnt == n0; n++)
      @(posedge pclk);
  endtask

  task automatic wake;
    for (int n = 0; n < 400 && (cpu_out.halt_mode | cpu_out.idle_mode) !== 1'b0; n++)
      @(posedge pclk);
  endtask

  task automatic low(input int i, input int n);
    pin[i] <= 1'b0;
    cyc(n);
    pin[i] <= 1'b1;
  endtask

  task automatic quiet;
    apb(1'b1, 5, 32'h0);
    apb(1'b1, 8, 32'h0);
    cyc(100);
  endtask

  function automatic logic [1:0] exp_lvl(input int i);
    return i < 6 ? {pr[1][i], pr[0][i]} : {pr[3][i - 6], pr[2][i - 6]};
  endfunction

  // winner: highest level, then lowest source number
  function automatic logic [3:0] exp_vec(input logic [13:0] m);
    logic [1:0] best;
    logic [1:0] l;
    logic [3:0] v;
    best = 2'h0;
    v = 4'hF;
    for (int i = 0; i < 14; i++)
    begin
      l = exp_lvl(i);
      if (m[i] && (v == 4'hF || l > best))
      begin
        best = l;
        v = 4'(i);
      end
    end
    return v;
  endfunction

  // ****
  // tests
  // ****
  initial
  begin
    int i;
    int k;
    logic [31:0] d;
    logic [31:0] pb;
    logic [13:0] m;
    logic [7:0] n0;
    d = $urandom(11);
    cyc(16);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 5; i++)
    begin
      apb(1'b0, i, 32'h0);
      chk(rd, ipw_pkg::RST_WORD);
      d = $urandom;
      if (i == 0)
        d[1:0] = 2'h0;
      apb(1'b1, i, d);
      apb(1'b0, i, 32'h0);
      chk(rd, d & (i == 0 ? 32'h8F : i < 3 ? 32'h3F : 32'hFF));
    end
    apb(1'b0, 10, 32'h0);
    chk({31'h0, err}, 32'h1);
    for (k = 0; k < 8; k++)
    begin
      for (i = 0; i < 4; i++)
      begin
        pr[i] = 8'($urandom);
        apb(1'b1, i + 1, {24'h0, pr[i]});
      end
      ack_dly <= 4'($urandom);
      d = k == 0 ? 32'h3FF : $urandom_range(1, 1023);
      m = 14'h0;
      for (i = 0; i < 10; i++)
        if (d[i])
          m[EVT_SRC[i]] = 1'b1;
      apb(1'b1, 5, 32'hBFFF);
      n0 = ack_cnt;
      fire(d[9:0]);
      chk({30'h0, cpu_out.irq_level}, {30'h0, exp_lvl(exp_vec(m))});
      chk({28'h0, ack_vec}, {28'h0, exp_vec(m)});
      cyc(10);
      chk({24'h0, ack_cnt}, {24'h0, n0 + 8'h1});
      quiet;
    end
    pr = '{8'h0, 8'h0, 8'h1, 8'h1};
    for (i = 0; i < 4; i++)
      apb(1'b1, i + 1, {24'h0, pr[i]});
    apb(1'b1, 5, 32'h8042);
    n0 = ack_cnt;
    fire(10'h001);
    fire(10'h010);
    chk({28'h0, ack_vec}, {28'h0, ipw_pkg::SRC_TIMER3});
    chk({24'h0, ack_cnt}, {24'h0, n0 + 8'h2});
    quiet;
    svc_len <= 8'h08;
    ack_dly <= 4'h0;
    apb(1'b1, 5, 32'h0002);
    apb(1'b1, 0, 32'h1);
    fire(10'h001);
    chk({31'h0, cpu_out.idle_mode}, 32'h1);
    apb(1'b1, 5, 32'h8002);
    wake;
    cyc(3);
    chk({28'h0, ack_vec}, 32'h1);
    quiet;
    apb(1'b1, 6, 32'h1);
    apb(1'b1, 5, 32'h8001);
    apb(1'b1, 0, 32'h1);
    low(0, 1);
    cyc(8);
    chk({31'h0, cpu_out.idle_mode}, 32'h1);
    low(0, 4);
    wake;
    cyc(3);
    chk({28'h0, ack_vec}, 32'h0);
    for (k = 0; k < 3; k++)
    begin
      quiet;
      apb(1'b1, 6, {31'h0, k == 0});
      apb(1'b1, 5, k == 2 ? 32'h8100 : 32'h8001);
      n0 = ack_cnt;
      low(k == 2 ? 2 : 0, 60);
      cyc(20);
      chk({31'h0, ack_cnt - n0 > 8'h1}, {31'h0, k == 1});
    end
    quiet;
    apb(1'b1, 5, 32'h0004);
    pin[1] <= 1'b0;
    cyc(4);
    apb(1'b1, 0, 32'h2);
    apb(1'b0, 0, 32'h0);
    chk({30'h0, cpu_out.halt_mode, rd[1]}, 32'h0);
    pin[1] <= 1'b1;
    pb = 32'h1 << $urandom_range(0, 31);
    apb(1'b1, 7, pb);
    for (k = 0; k < 5; k++)
    begin
      quiet;
      long_insn <= 1'($urandom);
      apb(1'b1, 5, HEN[k]);
      apb(1'b1, 0, 32'h2);
      cyc(2);
      chk({31'h0, cpu_out.halt_mode}, 32'h1);
      n0 = ack_cnt;
      if (k == 0)
      begin
        fire(10'h001);
        chk({31'h0, cpu_out.halt_mode}, 32'h1);
        low(2, 20);
      end
      else if (k < 3)
        low(2, 140);
      else
        port_pins <= port_pins ^ pb;
      wake;
      cyc(40);
      chk({31'h0, cpu_out.halt_mode}, 32'h0);
      chk({24'h0, ack_cnt - n0}, {24'h0, HNA[k]});
      if (HNA[k] == 8'h1)
        chk({28'h0, ack_vec}, {28'h0, HVE[k]});
    end
    results;
  end

  initial
  begin
    #2000000;
    miscompares++;
    results;
  end
endmodule
